// ===== pkg/pcpi_pkg.sv
package pcpi_pkg;

	// Word and bus widths
	localparam int WORD_W         = 20;
	localparam int ENH_W          = 8;
	localparam int BUS_W          = 8;

	// Sections of the counter word loaded by the three parallel strobes
	localparam int UPPER_LO       = 16;
	localparam int UPPER_W        = 4;
	localparam int MAIN_LO        = 8;
	localparam int LOW_LO         = 0;
	localparam int SECT_W         = 8;

	// Direct mode keeps only the bits below this position
	localparam int DIRECT_KEEP_W  = 16;

	// Reset values
	localparam logic [WORD_W-1:0] WORD_RST = 20'h00000;
	localparam logic [ENH_W-1:0]  ENH_RST  = 8'h00;

	// Enhancement byte, parallel bit 7 down to bit 0
	typedef struct packed {
		logic [2:0] reserved;
		logic       power_down;
		logic       counter_load;
		logic       mod_select_out;
		logic       prescaler_out;
		logic       output_disable;
	} pcpi_enh_s;

	// Single-bit pins that arrive from outside the clock domain
	typedef struct packed {
		logic upper_bits_strobe;
		logic main_div_strobe;
		logic low_bits_strobe;
		logic hop_strobe;
		logic enh_strobe;
		logic serial_commit;
		logic shift_clk;
		logic shift_data;
		logic direct_mode;
		logic serial_mode;
		logic enh_enable_n;
		logic serial_bank_select;
		logic parallel_bank_select;
		logic vco_div;
		logic ref_div;
		logic modulus_select;
		logic prescaler_raw;
	} pcpi_pins_s;

	typedef enum logic [1:0] {IF_PARALLEL, IF_SERIAL, IF_DIRECT} pcpi_mode_e;

	typedef enum logic [1:0] {PFD_IDLE, PFD_UP, PFD_DOWN} pcpi_pfd_e;

	function automatic pcpi_mode_e pcpi_decode_mode(input logic direct, input logic serial);
		if (direct)
			return IF_DIRECT;
		else if (serial)
			return IF_SERIAL;
		else
			return IF_PARALLEL;
	endfunction

endpackage

// ===== logic/pcpi_sync.sv
`timescale 1ns/1ps
module pcpi_sync
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             arst_n_in,
	// Asynchronous input and synchronised output
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta_q;

	// The first stage feeds the second stage only
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			meta_q <= '0;
			q_out  <= '0;
		end
		else
		begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end

endmodule

// ===== logic/pcpi_top.sv
`timescale 1ns/1ps
// Functional notes
// - Serial word shifts in, commit copies primary to secondary
// - Serial enhancement bits captured on strobe fall
// - Parallel enhancement byte latched on strobe rise
// - Enhancement byte field positions
// - Functions active high, reserved written zero
// - Power down stops all but programming
// - Counter load bit loads counters continuously
// - Modulus select shown on diagnostic output
// - Raw prescaler shown on diagnostic output
// - Phase detector acts on rising edges only
// - VCO leads: pump down pulses low
// - Reference leads: pump up pulses low
// - Pump pulse width follows phase difference
// - Up raises, down lowers VCO frequency
// - Lock filter is NAND of pumps
// - Lock detect is AND, open drain
// - Three strobes load three word sections
// - Bank select picks primary or secondary
// - Direct mode forces four upper bits zero
module pcpi_top
	import pcpi_pkg::*;
(
	// Clock and reset
	input  wire logic              CLOCK_IN,
	input  wire logic              ARST_N_IN,
	// Parallel bus and its strobes
	input  wire logic [BUS_W-1:0]  DATA_IN,
	input  wire logic              UPPER_BITS_STROBE_IN,
	input  wire logic              MAIN_DIV_STROBE_IN,
	input  wire logic              LOW_BITS_STROBE_IN,
	input  wire logic              HOP_STROBE_IN,
	input  wire logic              ENH_STROBE_IN,
	// Serial link
	input  wire logic              SERIAL_COMMIT_IN,
	input  wire logic              SHIFT_CLK_IN,
	input  wire logic              SHIFT_DATA_IN,
	// Direct word pins
	input  wire logic [WORD_W-1:0] DIRECT_WORD_IN,
	// Mode and bank selection
	input  wire logic              DIRECT_MODE_IN,
	input  wire logic              SERIAL_MODE_IN,
	input  wire logic              ENH_ENABLE_N_IN,
	input  wire logic              SERIAL_BANK_SELECT_IN,
	input  wire logic              PARALLEL_BANK_SELECT_IN,
	// Divided signals and prescaler taps
	input  wire logic              VCO_DIV_IN,
	input  wire logic              REF_DIV_IN,
	input  wire logic              MODULUS_SELECT_IN,
	input  wire logic              PRESCALER_RAW_IN,
	// Counter programming
	output logic      [WORD_W-1:0] COUNTER_WORD_OUT,
	// Phase detector and lock
	output logic                   PUMP_UP_N_OUT,
	output logic                   PUMP_DOWN_N_OUT,
	output logic                   LOCK_FILTER_OUT,
	output logic                   LOCK_DETECT_OUT,
	output logic                   LOCK_DETECT_OE_OUT,
	// Diagnostic and monitor outputs
	output logic                   DIAG_OUT,
	output logic                   VCO_MON_OUT,
	output logic                   REF_MON_OUT,
	output logic                   POWER_DOWN_OUT
);

	pcpi_pins_s        pins_raw;
	pcpi_pins_s        s;
	pcpi_pins_s        prev_q;
	pcpi_pins_s        rise;
	pcpi_pins_s        fall;
	logic [BUS_W-1:0]  data_s;
	logic [WORD_W-1:0] direct_s;
	pcpi_mode_e        mode;
	logic              enh_on;
	pcpi_enh_s         enh_q;
	pcpi_enh_s         eff;
	logic [ENH_W-1:0]  enh_shift_q;
	logic [WORD_W-1:0] primary_q;
	logic [WORD_W-1:0] secondary_q;
	logic [WORD_W-1:0] counter_d;
	logic              ser_word_shift;
	logic              ser_enh_shift;
	logic              enh_load;
	logic              commit;
	logic              bank;
	pcpi_pfd_e         pfd_q;
	pcpi_pfd_e         pfd_d;
	logic              diag_d;
	logic              mon_off;

	// Concatenation order must match the field order of the pin struct
	assign pins_raw = {UPPER_BITS_STROBE_IN, MAIN_DIV_STROBE_IN, LOW_BITS_STROBE_IN,
		HOP_STROBE_IN, ENH_STROBE_IN, SERIAL_COMMIT_IN, SHIFT_CLK_IN, SHIFT_DATA_IN,
		DIRECT_MODE_IN, SERIAL_MODE_IN, ENH_ENABLE_N_IN, SERIAL_BANK_SELECT_IN,
		PARALLEL_BANK_SELECT_IN, VCO_DIV_IN, REF_DIV_IN, MODULUS_SELECT_IN, PRESCALER_RAW_IN};

	// Data and strobes share the same latency, so a strobe edge sees the bus it qualified
	pcpi_sync #(.WIDTH($bits(pcpi_pins_s))) u_sync_pins
	(
		.clk_in    (CLOCK_IN),
		.arst_n_in (ARST_N_IN),
		.d_in      (pins_raw),
		.q_out     (s)
	);

	pcpi_sync #(.WIDTH(BUS_W)) u_sync_data
	(
		.clk_in    (CLOCK_IN),
		.arst_n_in (ARST_N_IN),
		.d_in      (DATA_IN),
		.q_out     (data_s)
	);

	pcpi_sync #(.WIDTH(WORD_W)) u_sync_direct
	(
		.clk_in    (CLOCK_IN),
		.arst_n_in (ARST_N_IN),
		.d_in      (DIRECT_WORD_IN),
		.q_out     (direct_s)
	);

	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			prev_q <= '0;
		else
			prev_q <= s;
	end

	assign rise   = s & ~prev_q;
	assign fall   = ~s & prev_q;
	assign mode   = pcpi_decode_mode(s.direct_mode, s.serial_mode);
	assign enh_on = !s.enh_enable_n;
	// Functions act only while enabled; reserved bits never steer anything
	assign eff    = enh_on ? enh_q : pcpi_enh_s'(ENH_RST);

	assign ser_word_shift = (mode == IF_SERIAL) && rise.shift_clk && !s.enh_strobe
		&& !s.serial_commit;
	assign ser_enh_shift  = (mode == IF_SERIAL) && rise.shift_clk && s.enh_strobe
		&& !s.serial_commit;

	// Primary word: first serial bit ends at the top, last at the bottom
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			primary_q <= WORD_RST;
		else if (ser_word_shift)
			primary_q <= {primary_q[WORD_W-2:0], s.shift_data};
		else if (mode == IF_PARALLEL)
		begin
			if (rise.upper_bits_strobe)
				primary_q[UPPER_LO +: UPPER_W] <= data_s[UPPER_W-1:0];
			if (rise.main_div_strobe)
				primary_q[MAIN_LO +: SECT_W] <= data_s;
			if (rise.low_bits_strobe)
				primary_q[LOW_LO +: SECT_W] <= data_s;
		end
	end

	// Counter load makes the secondary track the primary with no commit strobe
	assign commit = (rise.hop_strobe && mode != IF_DIRECT)
		|| (rise.serial_commit && mode == IF_SERIAL)
		|| eff.counter_load;

	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			secondary_q <= WORD_RST;
		else if (commit)
			secondary_q <= primary_q;
	end

	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			enh_shift_q <= ENH_RST;
		else if (ser_enh_shift)
			enh_shift_q <= {enh_shift_q[ENH_W-2:0], s.shift_data};
	end

	// Double buffer keeps the controls still while bits are being shifted
	assign enh_load = ((mode == IF_SERIAL) && fall.enh_strobe)
		|| ((mode == IF_PARALLEL) && rise.enh_strobe && enh_on);

	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			enh_q <= pcpi_enh_s'(ENH_RST);
		else if (enh_load)
			enh_q <= pcpi_enh_s'((mode == IF_SERIAL) ? enh_shift_q : data_s);
	end

	assign bank = (mode == IF_SERIAL) ? s.serial_bank_select : s.parallel_bank_select;

	always_comb
	begin
		if (mode == IF_DIRECT)
			counter_d = {{(WORD_W-DIRECT_KEEP_W){1'b0}}, direct_s[DIRECT_KEEP_W-1:0]};
		else if (bank)
			counter_d = primary_q;
		else
			counter_d = secondary_q;
	end

	// Programming stays live during power down; only the loop side stops
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			COUNTER_WORD_OUT <= WORD_RST;
		else
			COUNTER_WORD_OUT <= counter_d;
	end

	// Phase detector: a pulse lasts from the leading edge to the lagging one
	always_comb
	begin
		pfd_d = pfd_q;
		if (eff.power_down)
			pfd_d = PFD_IDLE;
		else
		begin
			case (pfd_q)
				PFD_IDLE:
				begin
					if (rise.ref_div && !rise.vco_div)
						pfd_d = PFD_UP;
					else if (rise.vco_div && !rise.ref_div)
						pfd_d = PFD_DOWN;
				end
				PFD_UP:
				begin
					if (rise.vco_div)
						pfd_d = PFD_IDLE;
				end
				PFD_DOWN:
				begin
					if (rise.ref_div)
						pfd_d = PFD_IDLE;
				end
				default:
					pfd_d = PFD_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			pfd_q <= PFD_IDLE;
		else
			pfd_q <= pfd_d;
	end

	// Up drives the loop toward a higher VCO frequency, down toward a lower one
	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			PUMP_UP_N_OUT      <= 1'b1;
			PUMP_DOWN_N_OUT    <= 1'b1;
			LOCK_FILTER_OUT    <= 1'b0;
			LOCK_DETECT_OUT    <= 1'b1;
			LOCK_DETECT_OE_OUT <= 1'b0;
		end
		else
		begin
			PUMP_UP_N_OUT      <= (pfd_d != PFD_UP);
			PUMP_DOWN_N_OUT    <= (pfd_d != PFD_DOWN);
			LOCK_FILTER_OUT    <= (pfd_d != PFD_IDLE);
			LOCK_DETECT_OUT    <= (pfd_d == PFD_IDLE);
			LOCK_DETECT_OE_OUT <= (pfd_d != PFD_IDLE);
		end
	end

	// Modulus select wins when both diagnostic bits are set
	always_comb
	begin
		if (eff.power_down)
			diag_d = 1'b0;
		else if (eff.mod_select_out)
			diag_d = s.modulus_select;
		else if (eff.prescaler_out)
			diag_d = s.prescaler_raw;
		else
			diag_d = 1'b0;
	end

	assign mon_off = eff.output_disable || eff.power_down;

	always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			DIAG_OUT       <= 1'b0;
			VCO_MON_OUT    <= 1'b0;
			REF_MON_OUT    <= 1'b0;
			POWER_DOWN_OUT <= 1'b0;
		end
		else
		begin
			DIAG_OUT       <= diag_d;
			VCO_MON_OUT    <= s.vco_div && !mon_off;
			REF_MON_OUT    <= s.ref_div && !mon_off;
			POWER_DOWN_OUT <= eff.power_down;
		end
	end

	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!ARST_N_IN);
	sequence s_up_open;
		(pfd_q == PFD_IDLE) && rise.ref_div && !rise.vco_div && !eff.power_down;
	endsequence
	sequence s_down_open;
		(pfd_q == PFD_IDLE) && rise.vco_div && !rise.ref_div && !eff.power_down;
	endsequence
	sequence s_up_close;
		(pfd_q == PFD_UP) && rise.vco_div;
	endsequence

	a_serial_shift: assert property (ser_word_shift |=>
		primary_q == {$past(primary_q[WORD_W-2:0]), $past(s.shift_data)})
		else $error("serial word shift wrong");
	a_serial_commit: assert property ((mode == IF_SERIAL) && rise.serial_commit |=>
		secondary_q == $past(primary_q))
		else $error("serial commit did not copy primary");
	a_enh_capture: assert property ((mode == IF_SERIAL) && fall.enh_strobe |=>
		enh_q == $past(enh_shift_q))
		else $error("enhancement capture wrong");
	a_enh_hold: assert property (!enh_load |=> $stable(enh_q))
		else $error("enhancement changed without load");
	a_par_enh: assert property ((mode == IF_PARALLEL) && rise.enh_strobe && enh_on |=>
		enh_q == $past(data_s))
		else $error("parallel enhancement latch wrong");
	a_par_upper: assert property ((mode == IF_PARALLEL) && rise.upper_bits_strobe |=>
		primary_q[UPPER_LO +: UPPER_W] == $past(data_s[UPPER_W-1:0]))
		else $error("upper section load wrong");
	a_direct_force: assert property (mode == IF_DIRECT |=>
		COUNTER_WORD_OUT[WORD_W-1:DIRECT_KEEP_W] == '0)
		else $error("direct mode upper bits not zero");
	a_bank_primary: assert property (mode != IF_DIRECT && bank |=>
		COUNTER_WORD_OUT == $past(primary_q))
		else $error("bank select high not primary");
	a_counter_load: assert property (eff.counter_load |=> secondary_q == $past(primary_q))
		else $error("counter load not continuous");
	a_pump_up: assert property (s_up_open |=> !PUMP_UP_N_OUT && PUMP_DOWN_N_OUT)
		else $error("pump up did not start");
	a_pump_down: assert property (s_down_open |=> !PUMP_DOWN_N_OUT && PUMP_UP_N_OUT)
		else $error("pump down did not start");
	a_pump_end: assert property (s_up_close |=> PUMP_UP_N_OUT)
		else $error("pump up did not end on vco edge");
	a_lock_tie: assert property (LOCK_FILTER_OUT == !(PUMP_UP_N_OUT && PUMP_DOWN_N_OUT)
		&& LOCK_DETECT_OE_OUT == LOCK_FILTER_OUT && LOCK_DETECT_OUT == !LOCK_FILTER_OUT)
		else $error("lock filter or detect mismatch");
	a_power_down: assert property (eff.power_down |=>
		PUMP_UP_N_OUT && PUMP_DOWN_N_OUT && !DIAG_OUT && !VCO_MON_OUT)
		else $error("power down left loop active");
	a_diag_modsel: assert property (!eff.power_down && eff.mod_select_out |=>
		DIAG_OUT == $past(s.modulus_select))
		else $error("diagnostic output not modulus select");
	a_mon_disable: assert property (eff.output_disable |=> !VCO_MON_OUT && !REF_MON_OUT)
		else $error("monitor outputs not disabled");

endmodule

// ===== bench/pcpi_host_model.sv
`timescale 1ns/1ps
module pcpi_host_model
	import pcpi_pkg::*;
(
	// Clock used only to pace the host
	input  wire logic             clk_in,
	// Host pins toward the block
	output logic      [BUS_W-1:0] data_out,
	output logic                  upper_out,
	output logic                  main_out,
	output logic                  low_out,
	output logic                  hop_out,
	output logic                  enh_out,
	output logic                  commit_out,
	output logic                  sclk_out,
	output logic                  sdata_out,
	output logic                  direct_out,
	output logic                  serial_out
);
	initial
	begin
		data_out = 8'h5a;
		{upper_out, main_out, low_out, hop_out, enh_out, commit_out, sclk_out} = 7'h00;
		{sdata_out, direct_out, serial_out} = 3'h0;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	// Each strobe phase lasts four clocks so the synchroniser never misses it
	task automatic strobe(input int sel, input logic v);
		case (sel)
			0: upper_out = v;
			1: main_out = v;
			2: low_out = v;
			3: enh_out = v;
			4: hop_out = v;
			default: commit_out = v;
		endcase
	endtask

	task automatic mode(input logic direct, input logic serial);
		direct_out = direct;
		serial_out = serial;
		hold(4);
	endtask

	task automatic par_wr(input int sel, input logic [7:0] d);
		data_out = (sel == 3) ? (d & 8'h1f) : d;
		hold(4);
		strobe(sel, 1'b1);
		hold(4);
		strobe(sel, 1'b0);
		hold(2);
		data_out = ~d;
		hold(1);
	endtask

	// Word bits leave MSB first; enhancement bytes are sent with reserved bits zero
	task automatic ser(input logic [19:0] w, input int n, input logic enh);
		if (enh)
			w[7:5] = 3'h0;
		enh_out = enh;
		hold(4);
		for (int i = n - 1; i >= 0; i--)
		begin
			sdata_out = w[i];
			hold(4);
			sclk_out = 1'b1;
			hold(4);
			sclk_out = 1'b0;
		end
		sdata_out = ~sdata_out;
		hold(4);
		enh_out = 1'b0;
		hold(4);
	endtask
endmodule

// ===== bench/tb_pcpi_top.sv
`timescale 1ns/1ps
module tb_pcpi_top
	import pcpi_pkg::*;
;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [19:0] dw = 20'h0;
	logic        enh_n = 1'b0, sbank = 1'b0, pbank = 1'b0;
	logic        vco = 1'b0, rfd = 1'b0, modsel = 1'b0, praw = 1'b0;
	wire  [7:0]  d;
	wire         ub, mb, lb, hb, eb, cm, sc, sd, dm, sm;
	wire  [19:0] word;
	wire         up_n, dn_n, lf, lock_det, oe, diag, vmon, rmon, pd;
	wire  [28:0] obs = {oe, diag, vmon, rmon, pd, up_n, dn_n, lf, lock_det, word};
	logic [57:0] exp_q[$];
	logic [57:0] e;
	logic [7:0]  r0, r1, r2;
	logic [19:0] w;
	int          fail_count = 0, n_tests = 0, cyc = 0;
	event        chk;
	logic [7:0]  e_t[4] = '{8'h04, 8'h02, 8'h01, 8'h10};
	logic [3:0]  x_t[4] = '{4'he, 4'he, 4'h0, 4'h1};

	initial
	begin
		forever #2.5 clk = ~clk;
	end

	pcpi_host_model host (.clk_in(clk), .data_out(d), .upper_out(ub), .main_out(mb),
		.low_out(lb), .hop_out(hb), .enh_out(eb), .commit_out(cm), .sclk_out(sc),
		.sdata_out(sd), .direct_out(dm), .serial_out(sm));

	pcpi_top uut (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .DATA_IN(d), .UPPER_BITS_STROBE_IN(ub),
		.MAIN_DIV_STROBE_IN(mb), .LOW_BITS_STROBE_IN(lb), .HOP_STROBE_IN(hb),
		.ENH_STROBE_IN(eb), .SERIAL_COMMIT_IN(cm), .SHIFT_CLK_IN(sc), .SHIFT_DATA_IN(sd),
		.DIRECT_WORD_IN(dw), .DIRECT_MODE_IN(dm), .SERIAL_MODE_IN(sm),
		.ENH_ENABLE_N_IN(enh_n), .SERIAL_BANK_SELECT_IN(sbank),
		.PARALLEL_BANK_SELECT_IN(pbank), .VCO_DIV_IN(vco), .REF_DIV_IN(rfd),
		.MODULUS_SELECT_IN(modsel), .PRESCALER_RAW_IN(praw), .COUNTER_WORD_OUT(word),
		.PUMP_UP_N_OUT(up_n), .PUMP_DOWN_N_OUT(dn_n), .LOCK_FILTER_OUT(lf),
		.LOCK_DETECT_OUT(lock_det), .LOCK_DETECT_OE_OUT(oe), .DIAG_OUT(diag), .VCO_MON_OUT(vmon),
		.REF_MON_OUT(rmon), .POWER_DOWN_OUT(pd));

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Ten clocks covers the worst pin-to-output latency with margin
	task automatic note_exp(input logic [28:0] m, input logic [28:0] v);
		exp_q.push_back({m, v & m});
		repeat (10) @(negedge clk);
		->chk;
		@(negedge clk);
	endtask

	always @(chk)
	begin
		e = exp_q.pop_front();
		n_tests++;
		if ((obs & e[57:29]) !== e[28:0])
		begin
			fail_count++;
			$display("Error t=%0t exp=%h got=%h", $time, e[28:0], obs & e[57:29]);
		end
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			close_out();
		end
	end

	initial
	begin
		void'($urandom(32'hf850f46b));
		repeat (6) @(negedge clk);
		arst_n = 1'b1;
		host.mode(1'b0, 1'b0);
		r0 = 8'($urandom);
		r1 = 8'($urandom);
		r2 = 8'($urandom);
		host.par_wr(0, r0);
		host.par_wr(1, r1);
		host.par_wr(2, r2);
		pbank = 1'b1;
		note_exp(28'hfffff, {r0[3:0], r1, r2});
		host.par_wr(4, 8'h00);
		host.par_wr(1, ~r1);
		pbank = 1'b0;
		note_exp(28'hfffff, {r0[3:0], r1, r2});
		pbank = 1'b1;
		note_exp(28'hfffff, {r0[3:0], ~r1, r2});
		// Continuous load: secondary follows primary with no hop strobe
		host.par_wr(3, 8'h08);
		pbank = 1'b0;
		host.par_wr(2, ~r2);
		note_exp(28'hfffff, {r0[3:0], ~r1, ~r2});
		host.par_wr(3, 8'h00);
		{vco, rfd} = 2'b11;
		for (int i = 0; i < 4; i++)
		begin
			modsel = e_t[i][2];
			praw = e_t[i][1];
			host.par_wr(3, e_t[i]);
			note_exp(28'hf000000, {x_t[i], 24'h0});
		end
		// Disabled functions: the stored power-down byte stops acting and refuses writes
		enh_n = 1'b1;
		note_exp(28'h1000000, 28'h0);
		host.par_wr(3, 8'h00);
		enh_n = 1'b0;
		note_exp(28'h1000000, 28'h1000000);
		host.par_wr(3, 8'h00);
		{vco, rfd} = 2'b00;
		host.mode(1'b0, 1'b1);
		w = 20'($urandom);
		host.ser(w, 20, 1'b0);
		sbank = 1'b1;
		note_exp(28'hfffff, w);
		host.par_wr(5, 8'h00);
		host.ser(~w, 20, 1'b0);
		sbank = 1'b0;
		note_exp(28'hfffff, w);
		host.ser(20'h10, 8, 1'b1);
		note_exp(28'h1000000, 28'h1000000);
		host.ser(20'h00, 8, 1'b1);
		note_exp(28'h1000000, 28'h0);
		host.mode(1'b1, 1'b0);
		dw = 20'($urandom);
		note_exp(28'hfffff, {4'h0, dw[15:0]});
		rfd = 1'b1;
		note_exp(29'h10f00000, 29'h10600000);
		rfd = 1'b0;
		note_exp(29'h10f00000, 29'h10600000);
		vco = 1'b1;
		note_exp(29'h10f00000, 29'h00d00000);
		vco = 1'b0;
		repeat (3) @(negedge clk);
		vco = 1'b1;
		note_exp(29'h10f00000, 29'h10a00000);
		rfd = 1'b1;
		note_exp(29'h10f00000, 29'h00d00000);
		close_out();
	end
endmodule
